// File: hdl/chan_cfg_pkg.sv
// Constants, register map and field layout of the channel configuration block.
package chan_cfg_pkg;

    // =========================================================
    // Bus shape
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int FILL_W = 8;

    // =========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] CHANNEL_SETUP_OFFSET = 11'h001;
    localparam logic [ADDR_W-1:0] RX_JITTER_OFFSET     = 11'h003;
    localparam logic [ADDR_W-1:0] TX_JITTER_OFFSET     = 11'h202;
    localparam logic [ADDR_W-1:0] CHANNEL_STATUS_OFFSET = 11'h03F;

    // =========================================================
    // Field positions and reset values
    localparam int LINE_STD_BIT   = 0;
    localparam int SOFT_RST_BIT   = 1;
    localparam int ATT_BW_BIT     = 0;
    localparam int ATT_DP_LSB     = 1;
    localparam int ATT_DP_MSB     = 2;
    localparam int ATT_EN_BIT     = 3;
    localparam int ATT_LIMIT_BIT  = 4;
    localparam int ATT_FIELD_W    = 5;
    localparam logic [DATA_W-1:0] CHANNEL_SETUP_RESET = 8'h00;
    localparam logic [ATT_FIELD_W-1:0] ATT_SETUP_RESET = 5'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // Status register bits.
    localparam int ST_E1_BIT      = 0;
    localparam int ST_BUSY_BIT    = 1;
    localparam int ST_RX_FULL_BIT = 2;
    localparam int ST_RX_EMPT_BIT = 3;
    localparam int ST_TX_FULL_BIT = 4;
    localparam int ST_TX_EMPT_BIT = 5;
    localparam int ST_HWSEL_BIT   = 6;

    // =========================================================
    // Attenuator encodings
    localparam logic [FILL_W-1:0] DEPTH_128 = 8'h80;
    localparam logic [FILL_W-1:0] DEPTH_64  = 8'h40;
    localparam logic [FILL_W-1:0] DEPTH_32  = 8'h20;
    localparam logic [FILL_W-1:0] LIMIT_MARGIN = 8'h02;
    localparam logic [1:0] DP_CODE_128 = 2'h0;
    localparam logic [1:0] DP_CODE_64  = 2'h1;

    // Corner frequencies in millihertz.
    localparam int CORNER_W = 16;
    localparam logic [CORNER_W-1:0] CORNER_T1_WIDE   = 16'h1388;
    localparam logic [CORNER_W-1:0] CORNER_E1_WIDE   = 16'h1A72;
    localparam logic [CORNER_W-1:0] CORNER_T1_NARROW = 16'h04EC;
    localparam logic [CORNER_W-1:0] CORNER_E1_NARROW = 16'h0366;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SOFT_RST_MAX_NS = 1000;
    localparam int SOFT_RST_CYCLES = SOFT_RST_MAX_NS / CLK_PERIOD_NS;
    localparam int RST_CNT_W       = 7;
    localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(SOFT_RST_CYCLES);
    localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = 7'h01;

    // Attenuator index in per-attenuator arrays.
    localparam int ATT_RX = 0;
    localparam int ATT_TX = 1;

    typedef enum logic {RST_IDLE, RST_RUNNING} soft_rst_state_t;

endpackage

// File: hdl/atten_ctrl_if.sv
// Interface between the register bank and one attenuator limit checker.
`timescale 1ns/1ps
interface atten_ctrl_if;
    import chan_cfg_pkg::*;

    // Settings and FIFO state from the register bank.
    logic              enable;
    logic              limit_enable;
    logic [1:0]        depth_code;
    logic [FILL_W-1:0] fill_level;
    // Decoded depth and limit decisions.
    logic [FILL_W-1:0] depth_bits;
    logic              near_full;
    logic              near_empty;
    logic              adjust_fast;
    logic              adjust_slow;

    modport cfg (
        output enable, limit_enable, depth_code, fill_level,
        input  depth_bits, near_full, near_empty, adjust_fast, adjust_slow
    );
    modport lim (
        input  enable, limit_enable, depth_code, fill_level,
        output depth_bits, near_full, near_empty, adjust_fast, adjust_slow
    );
endinterface

// File: hdl/jitter_limit.sv
// Depth decode and rate limit decision for one jitter attenuator FIFO.
`timescale 1ns/1ps
module jitter_limit
    import chan_cfg_pkg::*;
(
    // Settings in, decisions out.
    atten_ctrl_if.lim ctl
);

    logic [FILL_W-1:0] full_mark;

    // =========================================================
    // Depth decode: the upper code bit alone selects the shortest FIFO.
    always_comb begin
        if (ctl.depth_code[1]) begin
            ctl.depth_bits = DEPTH_32;
        end else if (ctl.depth_code == DP_CODE_64) begin
            ctl.depth_bits = DEPTH_64;
        end else begin
            ctl.depth_bits = DEPTH_128;
        end
    end

    // =========================================================
    // Two-bit margins at both ends of the FIFO.
    assign full_mark      = ctl.depth_bits - LIMIT_MARGIN;
    assign ctl.near_full  = ctl.fill_level >= full_mark;
    assign ctl.near_empty = ctl.fill_level <= LIMIT_MARGIN;

    // Rate adjust only matters on an attenuator that is in the path.
    assign ctl.adjust_fast = ctl.enable && ctl.limit_enable && ctl.near_full;
    assign ctl.adjust_slow = ctl.enable && ctl.limit_enable && ctl.near_empty;

endmodule

// File: hdl/channel_config_jitter_atten.sv
// Per-channel configuration registers, channel soft reset and jitter attenuator control.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module channel_config_jitter_atten
    import chan_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                arst_n,
    // Register port.
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rd_data,
    // Hardware line standard pins.
    input  wire logic                hw_standard_select_enable_pin,
    input  wire logic                hw_line_standard_pin,
    // FIFO fill levels from the attenuators.
    input  wire logic [FILL_W-1:0]   rx_fill_level,
    input  wire logic [FILL_W-1:0]   tx_fill_level,
    // Channel control.
    output logic                     channel_soft_reset,
    output logic                     e1_mode,
    // Receive attenuator control.
    output logic                     rx_atten_active,
    output logic [FILL_W-1:0]        rx_atten_depth,
    output logic [CORNER_W-1:0]      rx_atten_corner_mhz,
    output logic                     rx_atten_speed_up,
    output logic                     rx_atten_slow_down,
    // Transmit attenuator control.
    output logic                     tx_atten_active,
    output logic [FILL_W-1:0]        tx_atten_depth,
    output logic [CORNER_W-1:0]      tx_atten_corner_mhz,
    output logic                     tx_atten_speed_up,
    output logic                     tx_atten_slow_down
);

    // =========================================================
    // Declarations
    logic                    hwsel_meta;
    logic                    hwsel_sync;
    logic                    hwstd_meta;
    logic                    hwstd_sync;
    logic                    line_standard_select;
    soft_rst_state_t         rst_state;
    logic [RST_CNT_W-1:0]    rst_count;
    logic                    rst_busy;
    logic                    setup_wr;
    logic                    rx_wr;
    logic                    tx_wr;
    logic                    start_reset;
    logic                    next_e1;
    logic [ATT_FIELD_W-1:0]  att_setup [2];
    logic [FILL_W-1:0]       fill_in   [2];
    logic                    att_wr    [2];
    logic                    near_full [2];
    logic                    near_empty[2];
    logic                    active_q  [2];
    logic [FILL_W-1:0]       depth_q   [2];
    logic [CORNER_W-1:0]     corner_q  [2];
    logic                    fast_q    [2];
    logic                    slow_q    [2];
    logic [DATA_W-1:0]       status_word;

    // =========================================================
    // Pin synchronisers
    // Both pins are board straps or jumpers and come from outside the
    // clock domain; only the second stage is read by any logic.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hwsel_meta <= 1'b0;
            hwsel_sync <= 1'b0;
            hwstd_meta <= 1'b0;
            hwstd_sync <= 1'b0;
        end else begin
            hwsel_meta <= hw_standard_select_enable_pin;
            hwsel_sync <= hwsel_meta;
            hwstd_meta <= hw_line_standard_pin;
            hwstd_sync <= hwstd_meta;
        end
    end

    // =========================================================
    // Write decode
    assign setup_wr    = wr_en && (addr == CHANNEL_SETUP_OFFSET);
    assign rx_wr       = wr_en && (addr == RX_JITTER_OFFSET);
    assign tx_wr       = wr_en && (addr == TX_JITTER_OFFSET);
    assign start_reset = setup_wr && wr_data[SOFT_RST_BIT];
    assign rst_busy    = (rst_state == RST_RUNNING);
    assign att_wr[ATT_RX] = rx_wr;
    assign att_wr[ATT_TX] = tx_wr;
    assign fill_in[ATT_RX] = rx_fill_level;
    assign fill_in[ATT_TX] = tx_fill_level;

    // =========================================================
    // Channel soft reset sequencer
    // The reset runs for a fixed count that fits the one microsecond
    // ceiling at this clock. A new start in the last cycle wins over the
    // self clear, so a request is never swallowed by a finishing reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_state <= RST_IDLE;
            rst_count <= '0;
        end else begin
            case (rst_state)
                RST_IDLE: begin
                    if (start_reset) begin
                        rst_state <= RST_RUNNING;
                        rst_count <= RST_CNT_LOAD;
                    end
                end
                RST_RUNNING: begin
                    if (start_reset) begin
                        rst_count <= RST_CNT_LOAD;
                    end else if (rst_count == RST_CNT_LAST) begin
                        rst_state <= RST_IDLE;
                        rst_count <= '0;
                    end else begin
                        rst_count <= rst_count - RST_CNT_LAST;
                    end
                end
                default: begin
                    rst_state <= RST_IDLE;
                    rst_count <= '0;
                end
            endcase
        end
    end

    // =========================================================
    // Line standard select
    // Only the asynchronous reset clears it; the channel reset leaves it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_standard_select <= CHANNEL_SETUP_RESET[LINE_STD_BIT];
        end else if (setup_wr) begin
            line_standard_select <= wr_data[LINE_STD_BIT];
        end
    end

    // The pin pair takes over the standard when hardware select is on.
    always_comb begin
        if (hwsel_sync) begin
            next_e1 = hwstd_sync;
        end else begin
            next_e1 = line_standard_select;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            e1_mode            <= 1'b0;
            channel_soft_reset <= 1'b0;
        end else begin
            e1_mode            <= next_e1;
            channel_soft_reset <= rst_busy;
        end
    end

    // =========================================================
    // Attenuator settings and limit checks
    // Index 0 is the receive attenuator and index 1 the transmit one; both
    // share one layout so that software handles them alike.
    for (genvar g = 0; g < 2; g++) begin : g_att
        atten_ctrl_if lim_if ();

        jitter_limit u_limit (
            .ctl (lim_if.lim)
        );

        assign lim_if.enable       = att_setup[g][ATT_EN_BIT];
        assign lim_if.limit_enable = att_setup[g][ATT_LIMIT_BIT];
        assign lim_if.depth_code   = att_setup[g][ATT_DP_MSB:ATT_DP_LSB];
        assign lim_if.fill_level   = fill_in[g];
        assign near_full[g]        = lim_if.near_full;
        assign near_empty[g]       = lim_if.near_empty;

        // Settings return to default during a channel reset; a write that
        // lands while the reset runs is dropped.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                att_setup[g] <= ATT_SETUP_RESET;
            end else if (rst_busy) begin
                att_setup[g] <= ATT_SETUP_RESET;
            end else if (att_wr[g]) begin
                att_setup[g] <= wr_data[ATT_FIELD_W-1:0];
            end
        end

        // Decisions are registered so every control output is a flop.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                active_q[g] <= 1'b0;
                depth_q[g]  <= DEPTH_128;
                fast_q[g]   <= 1'b0;
                slow_q[g]   <= 1'b0;
            end else begin
                active_q[g] <= lim_if.enable && !rst_busy;
                depth_q[g]  <= lim_if.depth_bits;
                fast_q[g]   <= lim_if.adjust_fast && !rst_busy;
                slow_q[g]   <= lim_if.adjust_slow && !rst_busy;
            end
        end

        // Corner frequency follows both the bandwidth bit and the standard.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                corner_q[g] <= CORNER_T1_WIDE;
            end else begin
                case ({att_setup[g][ATT_BW_BIT], next_e1})
                    2'b00: begin
                        corner_q[g] <= CORNER_T1_WIDE;
                    end
                    2'b01: begin
                        corner_q[g] <= CORNER_E1_WIDE;
                    end
                    2'b10: begin
                        corner_q[g] <= CORNER_T1_NARROW;
                    end
                    default: begin
                        corner_q[g] <= CORNER_E1_NARROW;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // Output wiring from the per-attenuator flops
    assign rx_atten_active     = active_q[ATT_RX];
    assign rx_atten_depth      = depth_q[ATT_RX];
    assign rx_atten_corner_mhz = corner_q[ATT_RX];
    assign rx_atten_speed_up   = fast_q[ATT_RX];
    assign rx_atten_slow_down  = slow_q[ATT_RX];
    assign tx_atten_active     = active_q[ATT_TX];
    assign tx_atten_depth      = depth_q[ATT_TX];
    assign tx_atten_corner_mhz = corner_q[ATT_TX];
    assign tx_atten_speed_up   = fast_q[ATT_TX];
    assign tx_atten_slow_down  = slow_q[ATT_TX];

    // =========================================================
    // Status word
    // Live state for software; the FIFO margins show even with the limit
    // off, which helps when tuning depth before enabling adjustment.
    always_comb begin
        status_word                 = READ_ZERO;
        status_word[ST_E1_BIT]      = next_e1;
        status_word[ST_BUSY_BIT]    = rst_busy;
        status_word[ST_RX_FULL_BIT] = near_full[ATT_RX];
        status_word[ST_RX_EMPT_BIT] = near_empty[ATT_RX];
        status_word[ST_TX_FULL_BIT] = near_full[ATT_TX];
        status_word[ST_TX_EMPT_BIT] = near_empty[ATT_TX];
        status_word[ST_HWSEL_BIT]   = hwsel_sync;
    end

    // =========================================================
    // Read port
    // Data stands only in the cycle after the strobe; unmapped reads give
    // zero, as do all reserved bits.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= READ_ZERO;
        end else if (rd_en) begin
            case (addr)
                CHANNEL_SETUP_OFFSET: begin
                    rd_data                <= READ_ZERO;
                    rd_data[SOFT_RST_BIT]  <= rst_busy;
                    rd_data[LINE_STD_BIT]  <= line_standard_select;
                end
                RX_JITTER_OFFSET: begin
                    rd_data <= {{(DATA_W-ATT_FIELD_W){1'b0}}, att_setup[ATT_RX]};
                end
                TX_JITTER_OFFSET: begin
                    rd_data <= {{(DATA_W-ATT_FIELD_W){1'b0}}, att_setup[ATT_TX]};
                end
                CHANNEL_STATUS_OFFSET: begin
                    rd_data <= status_word;
                end
                default: begin
                    rd_data <= READ_ZERO;
                end
            endcase
        end else begin
            rd_data <= READ_ZERO;
        end
    end

endmodule

// File: tb/chan_cfg_props.sv
// Checker for the channel configuration block, bound to its top module.
`timescale 1ns/1ps
module chan_cfg_props
    import chan_cfg_pkg::*;
(
    // Clock, reset and inputs.
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_en,
    input  wire logic                hw_standard_select_enable_pin,
    input  wire logic                hw_line_standard_pin,
    input  wire logic [FILL_W-1:0]   rx_fill_level,
    input  wire logic [FILL_W-1:0]   tx_fill_level,
    // Outputs under watch.
    input  wire logic                channel_soft_reset,
    input  wire logic                e1_mode,
    input  wire logic                rx_atten_active,
    input  wire logic [FILL_W-1:0]   rx_atten_depth,
    input  wire logic [CORNER_W-1:0] rx_atten_corner_mhz,
    input  wire logic                rx_atten_speed_up,
    input  wire logic                rx_atten_slow_down,
    input  wire logic                tx_atten_active,
    input  wire logic [FILL_W-1:0]   tx_atten_depth,
    input  wire logic                tx_atten_speed_up,
    input  wire logic                tx_atten_slow_down
);
    logic [7:0] hi_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // =========================================================
    // Counts the channel reset pulse length.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= channel_soft_reset ? hi_cnt + 8'h01 : 8'h00;
        end
    end

    // =========================================================
    // Assertions
    AST_SRST_START: assert property (wr_en && addr == CHANNEL_SETUP_OFFSET && wr_data[1] |-> ##2 channel_soft_reset)
        else $error("reset did not start");
    AST_SRST_BOUND: assert property (!(channel_soft_reset && hi_cnt >= 8'h64))
        else $error("reset too long");
    AST_RX_FAST: assert property (rx_atten_speed_up |-> 9'($past(rx_fill_level)) + 9'h002 >= 9'(rx_atten_depth))
        else $error("rx fast not near full");
    AST_RX_SLOW: assert property (rx_atten_slow_down |-> $past(rx_fill_level) <= 8'h02)
        else $error("rx slow not near empty");
    AST_TX_FAST: assert property (tx_atten_speed_up |-> 9'($past(tx_fill_level)) + 9'h002 >= 9'(tx_atten_depth))
        else $error("tx fast not near full");
    AST_TX_SLOW: assert property (tx_atten_slow_down |-> $past(tx_fill_level) <= 8'h02)
        else $error("tx slow not near empty");
    AST_BYPASS: assert property (rx_atten_speed_up || rx_atten_slow_down |-> rx_atten_active)
        else $error("rx adjust in bypass");
    AST_DEPTH: assert property (rx_atten_active |-> rx_atten_depth inside {8'h80, 8'h40, 8'h20})
        else $error("bad rx depth");
    AST_CORNER: assert property (rx_atten_active && $stable(e1_mode) |->
        (e1_mode ? rx_atten_corner_mhz inside {16'h1A72, 16'h0366} : rx_atten_corner_mhz inside {16'h1388, 16'h04EC}))
        else $error("bad rx corner");
    AST_PIN_MODE: assert property ((hw_standard_select_enable_pin && $stable(hw_line_standard_pin) && !channel_soft_reset)[*4]
        |=> e1_mode == $past(hw_line_standard_pin))
        else $error("pin standard ignored");

    // =========================================================
    // Main scenarios reached.
    COV_SRST: cover property ($rose(channel_soft_reset));
    COV_RX_FAST: cover property (rx_atten_speed_up);
    COV_TX_SLOW: cover property (tx_atten_slow_down);
    COV_PIN: cover property (hw_standard_select_enable_pin && e1_mode);
endmodule

bind channel_config_jitter_atten chan_cfg_props u_props (.*);

// File: tb/host_model.sv
// Host processor model that programs the channel registers.
`timescale 1ns/1ps
module host_model
    import chan_cfg_pkg::*;
(
    // Clock.
    input  wire logic              clk,
    // Register port.
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wr_data,
    output logic                   wr_en,
    output logic                   rd_en,
    input  wire logic [DATA_W-1:0] rd_data
);
    // =========================================================
    // Idle bus from time zero.
    initial begin
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // =========================================================
    // Bus cycles; the address, and on writes the data, are inverted after use.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        addr    <= ~a;
        wr_data <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr  <= ~a;
        #1;
        d = rd_data;
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the channel configuration block.
`timescale 1ns/1ps
module tb_top;
    import chan_cfg_pkg::*;

    logic clk, arst_n, wr_en, rd_en, hw_en, hw_line;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [FILL_W-1:0] rx_fill_level, tx_fill_level, rx_atten_depth, tx_atten_depth;
    logic [CORNER_W-1:0] rx_atten_corner_mhz, tx_atten_corner_mhz;
    logic channel_soft_reset, e1_mode, rx_atten_active, tx_atten_active;
    logic rx_atten_speed_up, rx_atten_slow_down, tx_atten_speed_up, tx_atten_slow_down;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    host_model host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

    channel_config_jitter_atten uut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .hw_standard_select_enable_pin(hw_en), .hw_line_standard_pin(hw_line),
        .rx_fill_level(rx_fill_level), .tx_fill_level(tx_fill_level),
        .channel_soft_reset(channel_soft_reset), .e1_mode(e1_mode),
        .rx_atten_active(rx_atten_active), .rx_atten_depth(rx_atten_depth),
        .rx_atten_corner_mhz(rx_atten_corner_mhz), .rx_atten_speed_up(rx_atten_speed_up),
        .rx_atten_slow_down(rx_atten_slow_down), .tx_atten_active(tx_atten_active),
        .tx_atten_depth(tx_atten_depth), .tx_atten_corner_mhz(tx_atten_corner_mhz),
        .tx_atten_speed_up(tx_atten_speed_up), .tx_atten_slow_down(tx_atten_slow_down)
    );

    // =========================================================
    // Clock and a ceiling on run length.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end

    // =========================================================
    // Helpers
    task automatic test_done();
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        host.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    function automatic logic [7:0] exp_depth(input logic [1:0] code);
        return code[1] ? 8'h20 : (code[0] ? 8'h40 : 8'h80);
    endfunction

    function automatic logic [15:0] exp_corner(input logic bw, input logic e1);
        if (bw) return e1 ? 16'h0366 : 16'h04EC;
        return e1 ? 16'h1A72 : 16'h1388;
    endfunction

    // =========================================================
    // Scenarios
    task automatic t_defaults();
        rchk(CHANNEL_SETUP_OFFSET, 8'h00);
        rchk(RX_JITTER_OFFSET, 8'h00);
        rchk(TX_JITTER_OFFSET, 8'h00);
        chk(16'(rx_atten_depth), 16'h0080);
        chk(tx_atten_corner_mhz, 16'h1388);
        chk(16'(rx_atten_active), 16'h0000);
        chk(16'(e1_mode), 16'h0000);
    endtask

    // All depth and corner codes in both standards; tx gets the inverse.
    task automatic t_fields();
        logic [7:0] v;
        for (int e = 0; e < 2; e++) begin
            host.wr(CHANNEL_SETUP_OFFSET, 8'(e));
            for (int c = 0; c < 8; c++) begin
                v = 8'h08 | 8'(c);
                host.wr(RX_JITTER_OFFSET, v);
                host.wr(TX_JITTER_OFFSET, v ^ 8'h07);
                settle(2);
                chk(16'(e1_mode), 16'(e));
                chk(16'(rx_atten_active), 16'h0001);
                chk(16'(tx_atten_active), 16'h0001);
                chk(16'(rx_atten_depth), 16'(exp_depth(v[2:1])));
                chk(16'(tx_atten_depth), 16'(exp_depth(~v[2:1])));
                chk(rx_atten_corner_mhz, exp_corner(v[0], e[0]));
                chk(tx_atten_corner_mhz, exp_corner(~v[0], e[0]));
                rchk(TX_JITTER_OFFSET, v ^ 8'h07);
            end
        end
    endtask

    // Fill levels around the margins of a 32-bit FIFO.
    task automatic t_limit();
        logic [7:0] f [6] = '{8'h00, 8'h02, 8'h03, 8'h1D, 8'h1E, 8'h20};
        host.wr(RX_JITTER_OFFSET, 8'h1C);
        host.wr(TX_JITTER_OFFSET, 8'h1C);
        foreach (f[i]) begin
            @(posedge clk);
            rx_fill_level <= f[i];
            tx_fill_level <= f[i];
            settle(2);
            chk(16'(rx_atten_speed_up), 16'(f[i] >= 8'h1E));
            chk(16'(rx_atten_slow_down), 16'(f[i] <= 8'h02));
            chk(16'(tx_atten_speed_up), 16'(f[i] >= 8'h1E));
            chk(16'(tx_atten_slow_down), 16'(f[i] <= 8'h02));
        end
        host.wr(RX_JITTER_OFFSET, 8'h14);
        host.wr(TX_JITTER_OFFSET, 8'h0C);
        settle(2);
        chk(16'(rx_atten_speed_up), 16'h0000);
        chk(16'(rx_atten_active), 16'h0000);
        chk(16'(tx_atten_speed_up), 16'h0000);
        rchk(CHANNEL_STATUS_OFFSET, 8'h15);
        @(posedge clk);
        rx_fill_level <= 8'h00;
        tx_fill_level <= 8'h00;
    endtask

    // Writes in the reset are dropped; the standard bit survives.
    task automatic t_soft_reset();
        int n;
        host.wr(RX_JITTER_OFFSET, 8'h1F);
        host.wr(CHANNEL_SETUP_OFFSET, 8'h03);
        host.wr(RX_JITTER_OFFSET, 8'h18);
        #1;
        chk(16'(channel_soft_reset), 16'h0001);
        chk(16'(rx_atten_active), 16'h0000);
        n = 1;
        while (channel_soft_reset === 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        chk(16'(n <= 100), 16'h0001);
        settle(2);
        rchk(CHANNEL_SETUP_OFFSET, 8'h01);
        rchk(RX_JITTER_OFFSET, 8'h00);
        chk(16'(e1_mode), 16'h0001);
    endtask

    task automatic t_pins();
        host.wr(CHANNEL_SETUP_OFFSET, 8'h01);
        @(posedge clk);
        hw_en <= 1'b1;
        settle(5);
        chk(16'(e1_mode), 16'h0000);
        @(posedge clk);
        hw_line <= 1'b1;
        host.wr(CHANNEL_SETUP_OFFSET, 8'h00);
        settle(5);
        chk(16'(e1_mode), 16'h0001);
        @(posedge clk);
        hw_en <= 1'b0;
        settle(5);
        chk(16'(e1_mode), 16'h0000);
        host.wr(11'h7FF, 8'hFF);
        rchk(11'h7FF, 8'h00);
    endtask

    // =========================================================
    // Main sequence.
    initial begin
        arst_n = 1'b0;
        hw_en = 1'b0;
        hw_line = 1'b0;
        rx_fill_level = 8'h00;
        tx_fill_level = 8'h00;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_defaults();
        t_fields();
        t_limit();
        t_soft_reset();
        t_pins();
        test_done();
    end
endmodule
